// >>> common/bank_mem_defs.vh
`ifndef BANK_MEM_DEFS_VH
`define BANK_MEM_DEFS_VH

// Address geometry.
`define ADDR_W            12
`define BANK_W            4
`define OFFS_W            8
`define DATA_W            8
`define MEM_DEPTH         4096

// Access bank split and target banks.
`define ACCESS_SPLIT      8'h60
`define ACCESS_LOW_BANK   4'h0
`define ACCESS_HIGH_BANK  4'hF

// Bank select register layout and reset value.
`define BANK_SEL_RESET    4'h0
`define BANK_SEL_UPPER    4'h0
`define BANK_SEL_ADDR     12'hFE0

// Program counter low byte location.
`define PCL_ADDR          12'hFF9

// Quarter-cycle phase codes.
`define Q1                2'h0
`define Q2                2'h1
`define Q3                2'h2
`define Q4                2'h3

// Access split used with the extended set enabled; same value as the normal split.
`define XACCESS_SPLIT     8'h60
`define XACCESS_WIN_END   8'h60

`endif

// >>> core/quarter_phase.v
`timescale 1ns/1ps
`default_nettype none
`include "bank_mem_defs.vh"

// Quarter-cycle sequencer: four core clocks make one instruction cycle.
module quarter_phase
(
  // Clock and reset
  input  wire       i_clock,
  input  wire       i_rst,
  // Phase
  output wire [1:0] o_phase
);
  reg [1:0] phase_reg;
  wire [1:0] phase_next;

  assign phase_next = phase_reg + 2'h1;
  assign o_phase    = phase_reg;

  always @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      phase_reg <= `Q1;
    else
      phase_reg <= phase_next;
  end
endmodule // quarter_phase

`default_nettype wire

// >>> core/data_ram.v
`timescale 1ns/1ps
`default_nettype none
`include "bank_mem_defs.vh"

// Byte-wide static RAM holding all sixteen banks.
module data_ram
(
  // Clock
  input  wire                 i_clock,
  // Read port
  input  wire [`ADDR_W-1:0]   i_raddr,
  output reg  [`DATA_W-1:0]   o_rdata,
  // Write port
  input  wire                 i_we,
  input  wire [`ADDR_W-1:0]   i_waddr,
  input  wire [`DATA_W-1:0]   i_wdata
);
  // Contents are not reset so they survive every reset.
  reg [`DATA_W-1:0] mem [0:`MEM_DEPTH-1];

  always @(posedge i_clock)
  begin
    if (i_we)
      mem[i_waddr] <= i_wdata;
    o_rdata <= mem[i_raddr];
  end
endmodule // data_ram

`default_nettype wire

// >>> core/banked_data_memory.v
`timescale 1ns/1ps
`default_nettype none
`include "bank_mem_defs.vh"


// ----------------------------------------------------------------
// Address formation and access for the banked data memory.
// ----------------------------------------------------------------
module banked_data_memory
(
  // Clock and reset
  input  wire                 i_clock,
  input  wire                 i_rst,
  // Configuration
  input  wire                 i_extended_instruction_set_enable,
  input  wire [`ADDR_W-1:0]   i_impl_limit_lo,
  input  wire [`ADDR_W-1:0]   i_impl_limit_hi,
  // Instruction operands from the pipeline
  input  wire                 i_op_valid,
  input  wire                 i_full_address_move_op,
  input  wire                 i_load_bank_literal_op,
  input  wire                 i_access_bit,
  input  wire [`OFFS_W-1:0]   i_offset,
  input  wire [`ADDR_W-1:0]   i_src_addr,
  input  wire [`ADDR_W-1:0]   i_dst_addr,
  input  wire [`DATA_W-1:0]   i_literal,
  input  wire                 i_write_en,
  input  wire [`DATA_W-1:0]   i_wdata,
  // Results to the pipeline
  output wire [1:0]           o_phase,
  output reg  [`DATA_W-1:0]   o_rdata,
  output reg  [`ADDR_W-1:0]   o_read_addr,
  output reg  [`ADDR_W-1:0]   o_write_addr,
  output reg                  o_flags_update,
  output reg                  o_pcl_write,
  output reg  [`DATA_W-1:0]   o_pcl_data,
  output wire [`DATA_W-1:0]   o_bank_select_register
);

  // --------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------

  // Resolves an eight-bit offset through bank register or access map.
  function [`ADDR_W-1:0] resolve;
    input                 access_bit;
    input [`BANK_W-1:0]   bank;
    input [`OFFS_W-1:0]   offs;
    input                 ext_set;
    reg   [`OFFS_W-1:0]   split;
    begin
      split = ext_set ? `XACCESS_SPLIT : `ACCESS_SPLIT;
      if (access_bit)
        resolve = {bank, offs};
      else if (offs < split)
        resolve = {`ACCESS_LOW_BANK, offs};
      else
        resolve = {`ACCESS_HIGH_BANK, offs};
    end
  endfunction

  // Reports whether an address falls in an implemented region.
  function implemented;
    input [`ADDR_W-1:0] a;
    input [`ADDR_W-1:0] lo;
    input [`ADDR_W-1:0] hi;
    begin
      implemented = (a >= lo) && (a <= hi);
    end
  endfunction

  // Reports whether the sequencer stands in the given quarter.
  function in_quarter;
    input [1:0] ph;
    input [1:0] q;
    begin
      in_quarter = (ph == q);
    end
  endfunction

  // --------------------------------------------------------------
  // Phase and bank register
  // --------------------------------------------------------------
  wire [1:0] phase;

  quarter_phase u_phase
  (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .o_phase (phase)
  );

  assign o_phase = phase;

  reg  [`BANK_W-1:0] bank_reg;
  reg  [`BANK_W-1:0] bank_next;

  // Only the low nibble exists; the upper nibble is tied to zero.
  assign o_bank_select_register = {`BANK_SEL_UPPER, bank_reg};

  // --------------------------------------------------------------
  // Quarter strobes
  // --------------------------------------------------------------
  wire latch_q1;
  wire read_q2;
  wire commit_q4;

  assign latch_q1  = in_quarter(phase, `Q1);
  assign read_q2   = in_quarter(phase, `Q2);
  assign commit_q4 = in_quarter(phase, `Q4);

  // --------------------------------------------------------------
  // Address resolution
  // --------------------------------------------------------------
  wire [`ADDR_W-1:0] banked_addr;
  wire [`ADDR_W-1:0] src_addr;
  wire [`ADDR_W-1:0] dst_addr;

  assign banked_addr = resolve(i_access_bit, bank_reg, i_offset,
                               i_extended_instruction_set_enable);
  assign src_addr = i_full_address_move_op ? i_src_addr : banked_addr;
  assign dst_addr = i_full_address_move_op ? i_dst_addr : banked_addr;

  // --------------------------------------------------------------
  // Operand latches
  // --------------------------------------------------------------
  reg [`ADDR_W-1:0] src_reg;
  reg [`ADDR_W-1:0] dst_reg;
  reg               wr_reg;
  reg [`DATA_W-1:0] wdata_reg;
  reg               lit_reg;
  reg [`DATA_W-1:0] literal_reg;

  always @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      src_reg     <= {`ADDR_W{1'b0}};
      dst_reg     <= {`ADDR_W{1'b0}};
      wr_reg      <= 1'b0;
      wdata_reg   <= {`DATA_W{1'b0}};
      lit_reg     <= 1'b0;
      literal_reg <= {`DATA_W{1'b0}};
    end
    else if (latch_q1)
    begin
      src_reg     <= src_addr;
      dst_reg     <= dst_addr;
      wr_reg      <= i_op_valid & i_write_en & ~i_load_bank_literal_op;
      wdata_reg   <= i_wdata;
      lit_reg     <= i_op_valid & i_load_bank_literal_op;
      literal_reg <= i_literal;
    end
  end

  // --------------------------------------------------------------
  // Memory access
  // --------------------------------------------------------------
  wire [`DATA_W-1:0] ram_rdata;
  wire               src_impl;
  wire               dst_impl;
  wire               ram_we;
  wire               dst_is_bank;
  wire               src_is_bank;
  wire               commit_write;
  wire               pcl_hit;

  assign src_impl   = implemented(src_reg, i_impl_limit_lo, i_impl_limit_hi);
  assign dst_impl   = implemented(dst_reg, i_impl_limit_lo, i_impl_limit_hi);
  assign dst_is_bank  = (dst_reg == `BANK_SEL_ADDR);
  assign src_is_bank  = (src_reg == `BANK_SEL_ADDR);
  assign pcl_hit      = (dst_reg == `PCL_ADDR);
  assign commit_write = wr_reg & commit_q4;
  assign ram_we       = commit_write & dst_impl & ~dst_is_bank;

  data_ram u_ram
  (
    .i_clock (i_clock),
    .i_raddr (src_reg),
    .o_rdata (ram_rdata),
    .i_we    (ram_we),
    .i_waddr (dst_reg),
    .i_wdata (wdata_reg)
  );

  // The RAM samples the latched source address on every edge. Only the
  // sample taken at the end of Q2 is kept: it reaches o_rdata one edge
  // later, at the end of Q3, and stands until the next instruction's Q3.
  // The bank register address is served from the register, not the RAM.
  reg read_impl_reg;
  reg read_bank_reg;
  reg read_pend_reg;

  always @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      read_impl_reg <= 1'b0;
      read_bank_reg <= 1'b0;
      read_pend_reg <= 1'b0;
    end
    else
    begin
      read_impl_reg <= src_impl;
      read_bank_reg <= src_is_bank;
      read_pend_reg <= read_q2;
    end
  end

  always @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      o_rdata <= {`DATA_W{1'b0}};
    else if (read_pend_reg)
    begin
      if (read_bank_reg)
        o_rdata <= o_bank_select_register;
      else if (read_impl_reg)
        o_rdata <= ram_rdata;
      else
        o_rdata <= {`DATA_W{1'b0}};
    end
  end

  // --------------------------------------------------------------
  // Bank register update
  // --------------------------------------------------------------
  // A load-literal op never carries a write, so the two sources of a new
  // bank value cannot meet in one instruction.
  always @*
  begin
    bank_next = bank_reg;
    if (commit_q4)
    begin
      if (lit_reg)
        bank_next = literal_reg[`BANK_W-1:0];
      else if (wr_reg & dst_is_bank)
        bank_next = wdata_reg[`BANK_W-1:0];
    end
  end

  always @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      bank_reg <= `BANK_SEL_RESET;
    else
      bank_reg <= bank_next;
  end

  // --------------------------------------------------------------
  // Resolved address reports
  // --------------------------------------------------------------
  always @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_read_addr  <= {`ADDR_W{1'b0}};
      o_write_addr <= {`ADDR_W{1'b0}};
    end
    else
    begin
      o_read_addr  <= src_reg;
      o_write_addr <= dst_reg;
    end
  end

  // --------------------------------------------------------------
  // Status and program counter pulses
  // --------------------------------------------------------------
  always @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_flags_update <= 1'b0;
      o_pcl_write    <= 1'b0;
      o_pcl_data     <= {`DATA_W{1'b0}};
    end
    else
    begin
      // Flags update regardless of whether the target exists.
      o_flags_update <= commit_write;
      o_pcl_write    <= commit_write & pcl_hit;
      if (commit_write & pcl_hit)
        o_pcl_data <= wdata_reg;
    end
  end
endmodule // banked_data_memory

`default_nettype wire

// >>> sim/pipe_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Pipeline side: issues one operation per call, valid for the Q1 of one instruction cycle.
// ----------------------------------------------------------------
module pipe_model
(
  // Clock and phase
  input  wire logic        i_clock,
  input  wire logic [1:0]  i_phase,
  // Operands
  output logic             o_valid,
  output logic             o_mv,
  output logic             o_ld,
  output logic             o_acc,
  output logic             o_we,
  output logic [7:0]       o_offs,
  output logic [11:0]      o_src,
  output logic [11:0]      o_dst,
  output logic [7:0]       o_val
);
  initial
  begin
    {o_valid, o_mv, o_ld, o_acc, o_we} = 5'h00;
    {o_offs, o_src, o_dst, o_val} = 40'h0;
  end

  // Offset, addresses and value are inverted once latched so stale values never match; the mode bits stay as issued.
  task automatic issue(input logic mv, ld, acc, we,
    input logic [7:0] offs, input logic [11:0] src, dst,
    input logic [7:0] val);
    begin
      @(negedge i_clock);
      while (i_phase != 2'h3)
        @(negedge i_clock);
      @(posedge i_clock);
      {o_valid, o_mv, o_ld, o_acc, o_we} <= {1'b1, mv, ld, acc, we};
      {o_offs, o_src, o_dst, o_val} <= {offs, src, dst, val};
      @(posedge i_clock);
      o_valid <= 1'b0;
      {o_offs, o_src, o_dst, o_val} <= ~{offs, src, dst, val};
      repeat (3) @(posedge i_clock);
      @(negedge i_clock);
    end
  endtask
endmodule // pipe_model
`default_nettype wire

// >>> sim/bank_mem_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Port checks for the banked data memory.
// ----------------------------------------------------------------
module bank_mem_assertions
(
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  // Watched outputs
  input  wire logic [1:0]  o_phase,
  input  wire logic [7:0]  o_rdata,
  input  wire logic        o_flags_update,
  input  wire logic        o_pcl_write,
  input  wire logic [7:0]  o_bank_select_register
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);

  phase_order_a: assert property (o_phase == 2'h0 |=> o_phase == 2'h1
    ##1 o_phase == 2'h2 ##1 o_phase == 2'h3 ##1 o_phase == 2'h0)
    else $error("phase order broken");
  bank_upper_a: assert property (o_bank_select_register[7:4] == 4'h0)
    else $error("bank upper bits set");
  bank_moves_a: assert property (o_phase != 2'h3 |=>
    $stable(o_bank_select_register))
    else $error("bank changed outside fourth quarter");
  rdata_moves_a: assert property (o_phase != 2'h2 |=> $stable(o_rdata))
    else $error("read data changed off its slot");
  flags_pulse_a: assert property (o_flags_update |->
    o_phase == 2'h0 ##1 !o_flags_update)
    else $error("flags pulse wrong");
  pcl_pulse_a: assert property (o_pcl_write |->
    o_phase == 2'h0 ##1 !o_pcl_write)
    else $error("counter write pulse wrong");
  pcl_flags_a: assert property (o_pcl_write |-> o_flags_update)
    else $error("counter write without flags");
  bank_reset_a: assert property ($fell(i_rst) |->
    o_bank_select_register == 8'h00 && o_phase == 2'h0)
    else $error("reset state wrong");
endmodule // bank_mem_assertions

bind banked_data_memory bank_mem_assertions chk_u (.i_clock(i_clock),
  .i_rst(i_rst), .o_phase(o_phase), .o_rdata(o_rdata),
  .o_flags_update(o_flags_update), .o_pcl_write(o_pcl_write),
  .o_bank_select_register(o_bank_select_register));
`default_nettype wire

// >>> sim/banked_data_memory_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Directed tests of address formation.
// ----------------------------------------------------------------
module banked_data_memory_tb;
  logic        i_clock;
  logic        i_rst;
  logic        ext_set;
  logic [11:0] hi;
  logic        vld, mv, ld, acc, we, fl, pw;
  logic [7:0]  offs, val, rdata, bank_select, pcd;
  logic [11:0] src, dst, ra, wa;
  logic [1:0]  ph;
  int          miscompares, n_checks, cycles;
  logic [11:0] amap [4] = '{12'h000, 12'h05F, 12'hF60, 12'hFFF};

  banked_data_memory dut_u (.i_clock(i_clock), .i_rst(i_rst),
    .i_extended_instruction_set_enable(ext_set), .i_impl_limit_lo(12'h000),
    .i_impl_limit_hi(hi), .i_op_valid(vld), .i_full_address_move_op(mv),
    .i_load_bank_literal_op(ld), .i_access_bit(acc), .i_offset(offs),
    .i_src_addr(src), .i_dst_addr(dst), .i_literal(val), .i_write_en(we),
    .i_wdata(val), .o_phase(ph), .o_rdata(rdata), .o_read_addr(ra),
    .o_write_addr(wa), .o_flags_update(fl), .o_pcl_write(pw),
    .o_pcl_data(pcd), .o_bank_select_register(bank_select));
  pipe_model pipe_u (.i_clock(i_clock), .i_phase(ph), .o_valid(vld),
    .o_mv(mv), .o_ld(ld), .o_acc(acc), .o_we(we), .o_offs(offs),
    .o_src(src), .o_dst(dst), .o_val(val));

  initial
  begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end

  task automatic chk(input string what, input logic [11:0] seen, exp);
    begin
      n_checks++;
      if (seen !== exp)
      begin
        miscompares++;
        $display("BAD %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask

  task automatic complete_run;
    begin
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask

  task automatic bank_ld(input logic [7:0] v);
    pipe_u.issue(1'b0, 1'b1, 1'b0, 1'b0, 8'h00, 12'h000, 12'h000, v);
  endtask

  task automatic rw(input logic a, w, input logic [7:0] o, v);
    pipe_u.issue(1'b0, 1'b0, a, w, o, 12'h000, 12'h000, v);
  endtask

  always @(posedge i_clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      miscompares++;
      complete_run;
    end
  end

  initial
  begin
    {i_rst, ext_set, hi} = {1'b1, 1'b0, 12'hFFF};
    {miscompares, n_checks, cycles} = {32'h0, 32'h0, 32'h0};
    repeat (20) @(posedge i_clock);
    i_rst <= 1'b0;
    @(negedge i_clock);
    chk("bank", {4'h0, bank_select}, 12'h000);
    bank_ld(8'hA5);
    chk("bank", {4'h0, bank_select}, 12'h005);
    rw(1'b1, 1'b1, 8'h34, 8'h5A);
    chk("waddr", wa, 12'h534);
    chk("flags", {11'h0, fl}, 12'h001);
    rw(1'b1, 1'b0, 8'h34, 8'h00);
    chk("rdata", {4'h0, rdata}, 12'h05A);
    chk("raddr", ra, 12'h534);
    $display("test banked done");
    foreach (amap[i])
    begin
      rw(1'b0, 1'b0, amap[i][7:0], 8'h00);
      chk("amap", ra, amap[i]);
    end
    ext_set <= 1'b1;
    rw(1'b0, 1'b0, 8'h20, 8'h00);
    chk("xmap", ra, 12'h020);
    ext_set <= 1'b0;
    pipe_u.issue(1'b1, 1'b0, 1'b0, 1'b1, 8'h00, 12'h534, 12'h0AB, 8'h00);
    chk("mv raddr", ra, 12'h534);
    chk("mv waddr", wa, 12'h0AB);
    $display("test map done");
    bank_ld(8'h09);
    rw(1'b1, 1'b1, 8'h12, 8'h66);
    hi <= 12'h7FF;
    rw(1'b1, 1'b1, 8'h12, 8'h77);
    chk("flags", {11'h0, fl}, 12'h001);
    rw(1'b1, 1'b0, 8'h12, 8'h00);
    chk("rdata", {4'h0, rdata}, 12'h000);
    hi <= 12'hFFF;
    rw(1'b1, 1'b0, 8'h12, 8'h00);
    chk("dropped", {4'h0, rdata}, 12'h066);
    bank_ld(8'h0F);
    rw(1'b1, 1'b1, 8'hF9, 8'h3C);
    chk("pcl", {3'h0, pw, pcd}, 12'h13C);
    rw(1'b1, 1'b1, 8'hE0, 8'hC7);
    chk("bank wr", {4'h0, bank_select}, 12'h007);
    rw(1'b0, 1'b0, 8'hE0, 8'h00);
    chk("bank rd", {4'h0, rdata}, 12'h007);
    $display("test limits done");
    @(posedge i_clock);
    i_rst <= 1'b1;
    repeat (3) @(posedge i_clock);
    i_rst <= 1'b0;
    @(negedge i_clock);
    chk("bank", {4'h0, bank_select}, 12'h000);
    bank_ld(8'h05);
    rw(1'b1, 1'b0, 8'h34, 8'h00);
    chk("kept", {4'h0, rdata}, 12'h05A);
    $display("test reset done");
    complete_run;
  end
endmodule // banked_data_memory_tb
`default_nettype wire
